//--- dhp_map.svh
/*
  Holds the register offsets, field positions, reset values and codes of the
  debug-halt safe-stop timer.
  Assumes inclusion by bare name from the package and the top module.
*/
// Contract
// - The debug-halt level, high while the debugger pauses the core, is event input 7.
// - The halt event is taken on a high level of its input, condition code 0x3, never an edge.
// - The halt event uses combine code 0x2, so only the input fires it, never a counter match.
// - The halt event fires in either count direction, with direction qualifier code 0x0.
// - Event 8 is enabled in the idle, active and transient states, so a halt is caught in any.
// - Event 8 clears all six phase outputs through clear mask 0x100, and no event sets them.
// - Event 8 stops the counter through stop mask bits 8 and 24 until it is restarted.
// - The halt event leaves the state-machine state unchanged.
`ifndef DHP_MAP_SVH
`define DHP_MAP_SVH

`define DHP_OFF_CTRL 8'h00
`define DHP_OFF_STOP 8'h04
`define DHP_OFF_COUNT 8'h08
`define DHP_OFF_LIMIT 8'h0C
`define DHP_OFF_STATE 8'h10
`define DHP_OFF_EVSTATE 8'h14
`define DHP_OFF_EVCTRL 8'h18
`define DHP_OFF_MATCH 8'h1C
`define DHP_OFF_OUTBASE 8'h20
`define DHP_OFF_OUTLAST 8'h4C
`define DHP_OFF_LEVEL 8'h50
`define DHP_OFF_IRQSTAT 8'h54
`define DHP_OFF_IRQMASK 8'h58
`define DHP_OFF_INPUTS 8'h5C

`define DHP_NUM_OUT 6
`define DHP_HALT_INPUT 7
`define DHP_HALT_EVENT 8
`define DHP_STOP_LOW_BIT 8
`define DHP_STOP_HIGH_BIT 24

`define DHP_CTRL_RUNL 0
`define DHP_CTRL_UPDN 1
`define DHP_CTRL_RUNH 16

`define DHP_EV_MATCHSEL_LSB 0
`define DHP_EV_SRCTYPE 5
`define DHP_EV_SRCSEL_LSB 6
`define DHP_EV_INCOND_LSB 10
`define DHP_EV_COMB_LSB 12
`define DHP_EV_STATELD 14
`define DHP_EV_STATEV_LSB 15
`define DHP_EV_DIR_LSB 21

`define DHP_COND_LOW 2'h0
`define DHP_COND_RISE 2'h1
`define DHP_COND_FALL 2'h2
`define DHP_COND_HIGH 2'h3
`define DHP_COMB_OR 2'h0
`define DHP_COMB_MATCH 2'h1
`define DHP_COMB_IO 2'h2
`define DHP_COMB_AND 2'h3
`define DHP_DIR_ANY 2'h0
`define DHP_DIR_UP 2'h1
`define DHP_DIR_DOWN 2'h2

`define DHP_RST_STOP 32'h0100_0100
`define DHP_RST_CLR 32'h0000_0100
`define DHP_RST_SET 32'h0000_0000
`define DHP_RST_LIMIT 32'hFFFF_FFFF

`define DHP_IRQ_HALT 0
`define DHP_IRQ_STOP 1

`endif

//--- dhp_pkg.sv
/*
  Holds the types of the debug-halt safe-stop timer.
  Assumes the constants header is on the include path.
*/
`include "dhp_map.svh"
package dhp_pkg;
  typedef enum logic [4:0] {
    DHP_ST_IDLE,
    DHP_ST_ACTIVE,
    DHP_ST_TRANSIENT
  } dhp_state_t;
  typedef logic [31:0] dhp_word_t;
  typedef logic [5:0] dhp_drive_t;
endpackage

//--- dhp_safe_stop.sv
/*
  Holds the debug-halt safe-stop timer: an APB register file, a two-half
  counter, one configurable event, six phase drives and an interrupt.
  Assumes an APB master on core_clk, synchronous inputs and a gate driver
  that treats a low drive as transistor off.
*/
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "dhp_map.svh"
module dhp_safe_stop (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire dhp_pkg::dhp_word_t pwdata,
  output dhp_pkg::dhp_word_t prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debugHalt,
  input wire logic [6:0] timerIn,
  output logic phaseAHighDrive,
  output logic phaseALowDrive,
  output logic phaseBHighDrive,
  output logic phaseBLowDrive,
  output logic phaseCHighDrive,
  output logic phaseCLowDrive,
  output logic irq
);
  import dhp_pkg::*;

  function automatic logic condHit(input logic [1:0] cond, input logic cur, input logic prev);
    logic hit;
    hit = 1'b0;
    case (cond)
      `DHP_COND_LOW: hit = ~cur;
      `DHP_COND_RISE: hit = cur & ~prev;
      `DHP_COND_FALL: hit = ~cur & prev;
      default: hit = cur;
    endcase
    return hit;
  endfunction

  function automatic logic isOffset(input logic [7:0] addr, input logic [7:0] off);
    return addr == off;
  endfunction

  logic runLow_q, runHigh_q, upDown_q;
  logic [15:0] countLow_q, countHigh_q, countLow_d, countHigh_d;
  logic countDown_q, countDown_d;
  dhp_word_t stopMask_q, limit_q, evState_q, evCtrl_q, match_q;
  logic [4:0] state_q;
  dhp_word_t outSet_q [`DHP_NUM_OUT];
  dhp_word_t outClr_q [`DHP_NUM_OUT];
  dhp_drive_t drive_q, forced_q;
  logic holdActive_q;
  logic [1:0] irqStat_q, irqMask_q;
  logic [7:0] inPrev_q;
  dhp_word_t rdata_q;
  logic slverr_q;

  logic [7:0] inputs;
  logic apbAccess, apbWrite, apbRead, addrOk;
  logic [3:0] input_source_select;
  logic ioHit, matchHit, dirOk, stateOk, combHit, evFire;
  logic stopLow, stopHigh, ctrlWrite;
  logic [`DHP_NUM_OUT-1:0] evSet, evClr;
  logic [2:0] outIdx;
  logic outIsClr, outHit;

  assign inputs = {debugHalt, timerIn};
  assign apbAccess = psel & penable;
  assign apbWrite = apbAccess & pwrite;
  assign apbRead = apbAccess & ~pwrite;
  assign ctrlWrite = apbWrite & isOffset(paddr, `DHP_OFF_CTRL);
  assign outHit = paddr >= `DHP_OFF_OUTBASE && paddr <= `DHP_OFF_OUTLAST && paddr[1:0] == 2'h0;
  assign outIdx = 3'((paddr - `DHP_OFF_OUTBASE) >> 3);
  assign outIsClr = paddr[2];

  always_comb begin
    addrOk = 1'b0;
    if (paddr[1:0] != 2'h0) begin
      addrOk = 1'b0;
    end else if (paddr <= `DHP_OFF_MATCH) begin
      addrOk = 1'b1;
    end else if (outHit) begin
      addrOk = 1'b1;
    end else if (paddr >= `DHP_OFF_LEVEL && paddr <= `DHP_OFF_INPUTS) begin
      addrOk = 1'b1;
    end
  end

  // Event qualification: input condition, combine, direction and state enable.
  always_comb begin
    input_source_select = evCtrl_q[`DHP_EV_SRCSEL_LSB +: 4];
    ioHit = 1'b0;
    if (input_source_select < 4'h8) begin
      ioHit = condHit(evCtrl_q[`DHP_EV_INCOND_LSB +: 2], inputs[input_source_select[2:0]],
                      inPrev_q[input_source_select[2:0]]);
    end
    matchHit = runLow_q && countLow_q == match_q[15:0];
    case (evCtrl_q[`DHP_EV_COMB_LSB +: 2])
      `DHP_COMB_OR: combHit = ioHit | matchHit;
      `DHP_COMB_MATCH: combHit = matchHit;
      `DHP_COMB_IO: combHit = ioHit;
      default: combHit = ioHit & matchHit;
    endcase
    case (evCtrl_q[`DHP_EV_DIR_LSB +: 2])
      `DHP_DIR_UP: dirOk = ~countDown_q;
      `DHP_DIR_DOWN: dirOk = countDown_q;
      default: dirOk = 1'b1;
    endcase
    stateOk = evState_q[state_q];
    evFire = combHit & dirOk & stateOk;
  end

  always_comb begin
    for (int i = 0; i < `DHP_NUM_OUT; i++) begin
      evClr[i] = evFire & outClr_q[i][`DHP_HALT_EVENT];
      evSet[i] = evFire & outSet_q[i][`DHP_HALT_EVENT] & ~evClr[i];
    end
  end

  assign stopLow = evFire & stopMask_q[`DHP_STOP_LOW_BIT];
  assign stopHigh = evFire & stopMask_q[`DHP_STOP_HIGH_BIT];

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      inPrev_q <= 8'h00;
    end else begin
      inPrev_q <= inputs;
    end
  end

  // A stop from the event wins over a restart written in the same cycle.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      runLow_q <= 1'b0;
      runHigh_q <= 1'b0;
      upDown_q <= 1'b0;
    end else begin
      if (ctrlWrite) begin
        runLow_q <= pwdata[`DHP_CTRL_RUNL];
        runHigh_q <= pwdata[`DHP_CTRL_RUNH];
        upDown_q <= pwdata[`DHP_CTRL_UPDN];
      end
      if (stopLow) begin
        runLow_q <= 1'b0;
      end
      if (stopHigh) begin
        runHigh_q <= 1'b0;
      end
    end
  end

  always_comb begin
    countLow_d = countLow_q;
    countDown_d = countDown_q;
    if (runLow_q && !stopLow) begin
      if (countDown_q) begin
        if (countLow_q == 16'h0000) begin
          countDown_d = 1'b0;
          countLow_d = 16'h0001;
        end else begin
          countLow_d = countLow_q - 16'h0001;
        end
      end else if (countLow_q >= limit_q[15:0]) begin
        if (upDown_q) begin
          countDown_d = 1'b1;
          countLow_d = countLow_q - 16'h0001;
        end else begin
          countLow_d = 16'h0000;
        end
      end else begin
        countLow_d = countLow_q + 16'h0001;
      end
    end
    countHigh_d = countHigh_q;
    if (runHigh_q && !stopHigh) begin
      if (countHigh_q >= limit_q[31:16]) begin
        countHigh_d = 16'h0000;
      end else begin
        countHigh_d = countHigh_q + 16'h0001;
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      countLow_q <= 16'h0000;
      countHigh_q <= 16'h0000;
      countDown_q <= 1'b0;
    end else begin
      countLow_q <= countLow_d;
      countHigh_q <= countHigh_d;
      countDown_q <= countDown_d;
    end
  end

  // The state register only moves through software or a firing event, which loads or adds its state value.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      state_q <= DHP_ST_IDLE;
    end else if (evFire) begin
      if (evCtrl_q[`DHP_EV_STATELD]) begin
        state_q <= evCtrl_q[`DHP_EV_STATEV_LSB +: 5];
      end else begin
        state_q <= state_q + evCtrl_q[`DHP_EV_STATEV_LSB +: 5];
      end
    end else if (apbWrite && isOffset(paddr, `DHP_OFF_STATE)) begin
      state_q <= pwdata[4:0];
    end
  end

  // Event configuration comes out of reset already armed for the safe stop.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      stopMask_q <= `DHP_RST_STOP;
      limit_q <= `DHP_RST_LIMIT;
      match_q <= 32'h0000_0000;
      evState_q <= (32'h0000_0001 << DHP_ST_IDLE) | (32'h0000_0001 << DHP_ST_ACTIVE)
                   | (32'h0000_0001 << DHP_ST_TRANSIENT);
      evCtrl_q <= (32'(`DHP_DIR_ANY) << `DHP_EV_DIR_LSB)
                  | (32'(`DHP_COND_HIGH) << `DHP_EV_INCOND_LSB)
                  | (32'(`DHP_HALT_INPUT) << `DHP_EV_SRCSEL_LSB)
                  | (32'(`DHP_COMB_IO) << `DHP_EV_COMB_LSB);
      irqMask_q <= 2'h0;
    end else if (apbWrite) begin
      if (isOffset(paddr, `DHP_OFF_STOP)) begin
        stopMask_q <= pwdata;
      end else if (isOffset(paddr, `DHP_OFF_LIMIT)) begin
        limit_q <= pwdata;
      end else if (isOffset(paddr, `DHP_OFF_MATCH)) begin
        match_q <= {16'h0000, pwdata[15:0]};
      end else if (isOffset(paddr, `DHP_OFF_EVSTATE)) begin
        evState_q <= pwdata;
      end else if (isOffset(paddr, `DHP_OFF_EVCTRL)) begin
        evCtrl_q <= {9'h000, pwdata[22:0]};
      end else if (isOffset(paddr, `DHP_OFF_IRQMASK)) begin
        irqMask_q <= pwdata[1:0];
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      for (int i = 0; i < `DHP_NUM_OUT; i++) begin
        outSet_q[i] <= `DHP_RST_SET;
        outClr_q[i] <= `DHP_RST_CLR;
      end
    end else if (apbWrite && outHit && outIdx < 3'(`DHP_NUM_OUT)) begin
      if (outIsClr) begin
        outClr_q[outIdx] <= {16'h0000, pwdata[15:0]};
      end else begin
        outSet_q[outIdx] <= {16'h0000, pwdata[15:0]};
      end
    end
  end

  // Forced outputs stay cleared until a restart is written, even if software
  // writes the level register, so a paused core can never re-energise a winding.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      holdActive_q <= 1'b0;
      forced_q <= 6'h00;
    end else if (stopLow || stopHigh) begin
      holdActive_q <= 1'b1;
      forced_q <= forced_q | evClr;
    end else if (ctrlWrite && (pwdata[`DHP_CTRL_RUNL] || pwdata[`DHP_CTRL_RUNH])) begin
      holdActive_q <= 1'b0;
      forced_q <= 6'h00;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      drive_q <= 6'h00;
    end else begin
      for (int i = 0; i < `DHP_NUM_OUT; i++) begin
        if (evClr[i] || (holdActive_q && forced_q[i])) begin
          drive_q[i] <= 1'b0;
        end else if (evSet[i]) begin
          drive_q[i] <= 1'b1;
        end else if (apbWrite && isOffset(paddr, `DHP_OFF_LEVEL)) begin
          drive_q[i] <= pwdata[i];
        end
      end
    end
  end

  assign phaseAHighDrive = drive_q[0];
  assign phaseALowDrive = drive_q[1];
  assign phaseBHighDrive = drive_q[2];
  assign phaseBLowDrive = drive_q[3];
  assign phaseCHighDrive = drive_q[4];
  assign phaseCLowDrive = drive_q[5];

  // A new event in the cycle of the clearing read stays pending.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      irqStat_q <= 2'h0;
    end else begin
      if (apbRead && isOffset(paddr, `DHP_OFF_IRQSTAT)) begin
        irqStat_q <= 2'h0;
      end
      if (evFire) begin
        irqStat_q[`DHP_IRQ_HALT] <= 1'b1;
      end
      if (stopLow || stopHigh) begin
        irqStat_q[`DHP_IRQ_STOP] <= 1'b1;
      end
    end
  end

  assign irq = |(irqStat_q & irqMask_q);

  // Read data is registered in the setup cycle and presented in the access cycle.
  always_comb begin
    pready = psel & penable;
    prdata = rdata_q;
    pslverr = slverr_q;
  end

  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      rdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else if (psel && !penable) begin
      slverr_q <= ~addrOk;
      rdata_q <= 32'h0000_0000;
      if (pwrite || !addrOk) begin
        rdata_q <= 32'h0000_0000;
      end else if (isOffset(paddr, `DHP_OFF_CTRL)) begin
        rdata_q <= {15'h0000, runHigh_q, 14'h0000, upDown_q, runLow_q};
      end else if (isOffset(paddr, `DHP_OFF_STOP)) begin
        rdata_q <= stopMask_q;
      end else if (isOffset(paddr, `DHP_OFF_COUNT)) begin
        rdata_q <= {countHigh_q, countLow_q};
      end else if (isOffset(paddr, `DHP_OFF_LIMIT)) begin
        rdata_q <= limit_q;
      end else if (isOffset(paddr, `DHP_OFF_STATE)) begin
        rdata_q <= {27'h000_0000, state_q};
      end else if (isOffset(paddr, `DHP_OFF_EVSTATE)) begin
        rdata_q <= evState_q;
      end else if (isOffset(paddr, `DHP_OFF_EVCTRL)) begin
        rdata_q <= evCtrl_q;
      end else if (isOffset(paddr, `DHP_OFF_MATCH)) begin
        rdata_q <= match_q;
      end else if (outHit) begin
        if (outIdx >= 3'(`DHP_NUM_OUT)) begin
          rdata_q <= 32'h0000_0000;
        end else if (outIsClr) begin
          rdata_q <= outClr_q[outIdx];
        end else begin
          rdata_q <= outSet_q[outIdx];
        end
      end else if (isOffset(paddr, `DHP_OFF_LEVEL)) begin
        rdata_q <= {24'h00_0000, holdActive_q, 1'b0, drive_q};
      end else if (isOffset(paddr, `DHP_OFF_IRQSTAT)) begin
        rdata_q <= {30'h0000_0000, irqStat_q};
      end else if (isOffset(paddr, `DHP_OFF_IRQMASK)) begin
        rdata_q <= {30'h0000_0000, irqMask_q};
      end else begin
        rdata_q <= {24'h00_0000, inputs};
      end
    end
  end
endmodule // dhp_safe_stop

//--- dhp_gate_bridge.sv
/*
  Behavioural three-phase gate-driver bridge.
  Assumes a high drive turns its transistor on.
*/
`timescale 1ns/1ps
module dhp_gate_bridge (
  input wire logic [5:0] gateOn,
  output logic shootThrough,
  output logic windingCurrent
);
  logic [2:0] hi;
  logic [2:0] lo;
  assign hi = {gateOn[4], gateOn[2], gateOn[0]};
  assign lo = {gateOn[5], gateOn[3], gateOn[1]};
  // Both switches of one leg on would short the supply.
  assign shootThrough = |(hi & lo);
  assign windingCurrent = |(hi & {lo[0], lo[2], lo[1]}) || |(hi & {lo[1], lo[0], lo[2]});
endmodule // dhp_gate_bridge

//--- dhp_safe_stop_monitor.sv
/*
  Port checker for the debug-halt safe-stop timer.
  Assumes it is bound to the top module.
*/
`timescale 1ns/1ps
module dhp_safe_stop_monitor (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire dhp_pkg::dhp_word_t pwdata,
  input wire dhp_pkg::dhp_word_t prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic debugHalt,
  input wire logic phaseAHighDrive,
  input wire logic phaseALowDrive,
  input wire logic phaseBHighDrive,
  input wire logic phaseBLowDrive,
  input wire logic phaseCHighDrive,
  input wire logic phaseCLowDrive
);
  import dhp_pkg::*;
  dhp_drive_t drv;
  logic runWr;
  logic holdSeen_q;
  assign drv = {phaseCLowDrive, phaseCHighDrive, phaseBLowDrive, phaseBHighDrive,
    phaseALowDrive, phaseAHighDrive};
  assign runWr = psel && penable && pwrite && paddr == 8'h00 && (pwdata[0] || pwdata[16]);
  // Mirrors the hold so the forced levels can be checked across many cycles.
  always_ff @(posedge core_clk) begin
    if (!rstn) begin
      holdSeen_q <= 1'b0;
    end else if (debugHalt) begin
      holdSeen_q <= 1'b1;
    end else if (runWr) begin
      holdSeen_q <= 1'b0;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  halt_clears_a: assert property (debugHalt |=> drv == 6'h00)
    else $error("drives not cleared after halt");
  level_fires_a: assert property (debugHalt ##1 debugHalt |-> ##1 drv == 6'h00)
    else $error("held halt level not acting");
  hold_forced_a: assert property (holdSeen_q |-> drv == 6'h00)
    else $error("drive left forced level");
  halt_input_a: assert property (psel && penable && !pwrite && paddr == 8'h5C
    |-> prdata[7] == $past(debugHalt)) else $error("halt not seen on input 7");
  run_stopped_a: assert property ($past(holdSeen_q) && psel && penable && !pwrite
    && paddr == 8'h00 |-> !prdata[0] && !prdata[16]) else $error("counter still runs");
  pready_a: assert property (psel && penable |-> pready)
    else $error("access not answered");
  pready_idle_a: assert property (!(psel && penable) |-> !pready)
    else $error("ready outside access");
  addr_err_a: assert property (psel && penable
    |-> pslverr == (paddr > 8'h5C || paddr[1:0] != 2'h0)) else $error("wrong slave error");
endmodule // dhp_safe_stop_monitor

bind dhp_safe_stop dhp_safe_stop_monitor mon (.core_clk, .rstn, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .debugHalt, .phaseAHighDrive, .phaseALowDrive,
  .phaseBHighDrive, .phaseBLowDrive, .phaseCHighDrive, .phaseCLowDrive);

//--- test_dhp_safe_stop.sv
/*
  Testbench for the debug-halt safe-stop timer.
  Assumes the design, checker and bridge model are compiled first.
*/
`timescale 1ns/1ps
module test_dhp_safe_stop;
  import dhp_pkg::*;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  dhp_word_t pwdata = 32'h0;
  dhp_word_t prdata;
  logic pready;
  logic pslverr;
  logic debugHalt = 1'b0;
  dhp_drive_t drv;
  logic irq;
  logic shootThrough;
  logic windingCurrent;
  logic [8:0] pins;
  dhp_word_t v;
  dhp_word_t w;
  logic err;
  int n_mismatch = 0;
  int comparisons = 0;
  always #5 core_clk = ~core_clk;
  assign pins = {shootThrough, irq, windingCurrent, drv};
  dhp_safe_stop dut (.core_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .debugHalt, .timerIn(7'h00), .phaseAHighDrive(drv[0]),
    .phaseALowDrive(drv[1]), .phaseBHighDrive(drv[2]), .phaseBLowDrive(drv[3]),
    .phaseCHighDrive(drv[4]), .phaseCLowDrive(drv[5]), .irq);
  dhp_gate_bridge bridge (.gateOn(drv), .shootThrough, .windingCurrent);
  task automatic results();
    $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk_word(input dhp_word_t got, input dhp_word_t exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_pin(input logic [8:0] got, input logic [8:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: pins %b expected %b", $time, got, exp);
    end
  endtask
  // The request is held until pready is seen high, for at most 16 cycles.
  task automatic apb(input logic wr, input logic [7:0] a, input dhp_word_t d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_mismatch++;
      $display("Error at %0t: no ready", $time);
      results();
    end
    v = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic rdchk(input logic [7:0] a, input dhp_word_t exp);
    apb(1'b0, a, 32'h0);
    chk_word(v, exp);
  endtask
  task automatic halt();
    @(posedge core_clk);
    debugHalt <= 1'b1;
    @(posedge core_clk);
    debugHalt <= 1'b0;
    @(posedge core_clk);
    #1;
  endtask
  initial begin
    repeat (4) @(posedge core_clk);
    rstn <= 1'b1;
    rdchk(8'h04, 32'h0100_0100);
    rdchk(8'h18, (32'h2 << 12) | (32'h3 << 10) | (32'h7 << 6));
    rdchk(8'h14, 32'h0000_0007);
    for (int i = 0; i < 6; i++) begin
      rdchk(8'h24 + 8'(8 * i), 32'h0000_0100);
      rdchk(8'h20 + 8'(8 * i), 32'h0000_0000);
    end
    apb(1'b0, 8'h60, 32'h0);
    chk_pin({8'h00, err}, 9'h001);
    apb(1'b1, 8'h58, 32'h0000_0003);
    apb(1'b1, 8'h00, 32'h0001_0001);
    apb(1'b1, 8'h50, 32'h0000_0009);
    chk_pin(pins, 9'h049);
    apb(1'b0, 8'h08, 32'h0);
    w = v;
    apb(1'b0, 8'h08, 32'h0);
    chk_word({31'h0, v !== w}, 32'h1);
    apb(1'b1, 8'h10, 32'h0000_0002);
    halt();
    chk_pin(pins, 9'h080);
    apb(1'b0, 8'h08, 32'h0);
    w = v;
    repeat (5) @(posedge core_clk);
    rdchk(8'h08, w);
    rdchk(8'h00, 32'h0000_0000);
    rdchk(8'h10, 32'h0000_0002);
    apb(1'b1, 8'h50, 32'h0000_0009);
    chk_pin(pins, 9'h080);
    rdchk(8'h54, 32'h0000_0003);
    chk_pin(pins, 9'h000);
    rdchk(8'h54, 32'h0000_0000);
    // A held level must keep firing after its status was cleared by a read.
    apb(1'b1, 8'h58, 32'h0000_0000);
    @(posedge core_clk);
    debugHalt <= 1'b1;
    rdchk(8'h5C, 32'h0000_0080);
    apb(1'b0, 8'h54, 32'h0);
    apb(1'b0, 8'h54, 32'h0);
    chk_word(v & 32'h1, 32'h1);
    chk_pin(pins, 9'h000);
    @(posedge core_clk);
    debugHalt <= 1'b0;
    // A low limit of zero turns the low half round at once, so the next halt meets it counting down.
    apb(1'b1, 8'h0C, 32'hFFFF_0000);
    apb(1'b1, 8'h00, 32'h0001_0003);
    apb(1'b1, 8'h50, 32'h0000_0009);
    chk_pin(pins, 9'h049);
    apb(1'b1, 8'h58, 32'h0000_0003);
    apb(1'b0, 8'h54, 32'h0);
    halt();
    chk_pin(pins, 9'h080);
    rdchk(8'h00, 32'h0000_0002);
    rdchk(8'h08, 32'h0017_0003);
    results();
  end
endmodule // test_dhp_safe_stop
